// File: hdl/ctm_timer_top.sv
// Cascaded 8-bit timer pair with APB register slave
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ns

// Summary of operation
// - Event counter mode increments the 16-bit pair on each valid event edge.
// - 16-bit match clears both counters, keeps counting, raises only lower interrupt.
// - In 16-bit mode only the lower run bit starts and clears the pair.
// - 16-bit square wave toggles the lower output on every full match.
// - Lower run bit at 0 forces the square-wave output to 0.
// - Lower clock select picks main, main/4, or external input /1,/2,/4,/8.
// - Carrier mode: lower match interrupts, toggles, swaps low and high compare.
// - Upper match raises upper interrupt; its rising edge loads gate from buffer.
// - Carrier reaches the lower pin only while the gate bit is 1.
// - Carrier control holds remote select bit 2, buffer bit 1, gate bit 0.
// - Gate writes ignored while lower pin enabled; write during upper irq reloads.
// - PWM: overflow drives upper output high, match drives low and interrupts.
// - PPG: each match interrupts, toggles, clears counter and swaps compares.
// - A timer output pin starts low when its output is enabled, except the lower pin in carrier mode with remote select and gate both 1.
// - Upper counter is the high byte, lower counter the low byte.
module ctm_timer_top #(
   parameter int PRE_DIV = 4
) (
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [ctm_pkg::ADDR_W-1:0]   paddr,
   input  wire logic [ctm_pkg::DATA_W-1:0]   pwdata,
   output logic      [ctm_pkg::DATA_W-1:0]   prdata,
   output logic                               pready,
   output logic                               pslverr,
   input  wire logic                          event_input_pin,
   output logic                               upper_out_pin,
   output logic                               lower_out_pin,
   output logic                               upper_irq,
   output logic                               lower_irq
);
   import ctm_pkg::*;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
      return a == off;
   endfunction

   ctm_mode_t        mode_q;
   logic             pwm_en_q;
   ctm_ctrl_t        ctrl_q;
   ctm_cmp_t         cmp_q;
   ctm_carrier_t     car_q, car_d;
   logic [CNT_W-1:0] ucnt_q, ucnt_d, lcnt_q, lcnt_d;
   logic             hsel_q, hsel_d;
   logic             lwave_q, lwave_d, uwave_q, uwave_d;
   logic [1:0]       pre_q;
   logic [2:0]       ext_div_q;
   logic             ev_s1_q, ev_s2_q, ev_s3_q;
   logic             pready_q, pslverr_q, uirq_q, lirq_q, uout_q, lout_q;
   logic [DATA_W-1:0] prdata_q;

   // Bus decode
   wire setup    = psel & ~penable & ~pready_q;
   wire access   = psel & penable & pready_q;
   wire wr       = access & pwrite;
   // Writes answer with zero read data
   wire rd_go    = setup & ~pwrite;
   wire hit_mode = hit(paddr, OFF_MODE);
   wire hit_ctrl = hit(paddr, OFF_CTRL);
   wire hit_cmp  = hit(paddr, OFF_CMP);
   wire hit_car  = hit(paddr, OFF_CARRIER);
   wire hit_st   = hit(paddr, OFF_STATUS);
   wire mapped   = hit_mode | hit_ctrl | hit_cmp | hit_car | hit_st;

   wire cascade = mode_q == CTM_MODE_CASCADE;
   wire carrier = mode_q == CTM_MODE_CARRIER;
   wire pwm     = (mode_q == CTM_MODE_SPLIT) & pwm_en_q;

   // Count clock sources
   localparam logic [1:0] PRE_END = 2'(PRE_DIV - 1);
   wire pre_tick = pre_q == PRE_END;
   wire ev_rise  = ev_s2_q & ~ev_s3_q;

   logic [2:0] ext_mask;
   always_comb begin
      case (ctrl_q.lower_sel)
         SEL_EXT_D2: ext_mask = 3'h1;
         SEL_EXT_D4: ext_mask = 3'h3;
         SEL_EXT_D8: ext_mask = 3'h7;
         default:    ext_mask = 3'h0;
      endcase
   end
   wire ext_tick = ev_rise & ((ext_div_q & ext_mask) == ext_mask);

   logic lsrc;
   always_comb begin
      case (ctrl_q.lower_sel)
         SEL_MAIN:    lsrc = 1'b1;
         SEL_MAIN_D4: lsrc = pre_tick;
         SEL_EXT_D1,
         SEL_EXT_D2,
         SEL_EXT_D4,
         SEL_EXT_D8:  lsrc = ext_tick;
         default:     lsrc = 1'b0;
      endcase
   end

   wire lrun    = ctrl_q.lower_run;
   wire urun    = cascade ? ctrl_q.lower_run : ctrl_q.upper_run;
   wire ltick   = lrun & lsrc;
   wire utick   = ~cascade & urun & (ctrl_q.upper_sel ? pre_tick : 1'b1);
   wire [15:0] cnt16 = {ucnt_q, lcnt_q};
   wire [15:0] cmp16 = {cmp_q.upper_compare, cmp_q.lower_compare};
   wire match16 = cascade & ltick & (cnt16 == cmp16);
   wire [CNT_W-1:0] lcmp_sel = hsel_q ? cmp_q.carrier_high_compare : cmp_q.lower_compare;
   wire lmatch  = ~cascade & ltick & (lcnt_q == lcmp_sel);
   wire umatch  = utick & (ucnt_q == cmp_q.upper_compare);
   wire uovf    = utick & (ucnt_q == CNT_TOP);
   wire ucarry  = cascade & ltick & (lcnt_q == CNT_TOP);

   // Lower counter and its output wave
   always_comb begin
      lcnt_d  = lcnt_q;
      hsel_d  = hsel_q;
      lwave_d = lwave_q;
      // Dropping the run bit clears count, phase and wave
      if (!lrun) begin
         lcnt_d  = CNT_ZERO;
         hsel_d  = 1'b0;
         lwave_d = 1'b0;
      end else if (match16) begin
         lcnt_d  = CNT_ZERO;
         lwave_d = ~lwave_q;
      end else if (lmatch) begin
         lcnt_d  = CNT_ZERO;
         hsel_d  = ~hsel_q;
         lwave_d = ~lwave_q;
      end else if (ltick) begin
         lcnt_d  = lcnt_q + 8'h01;
      end
      if (!ctrl_q.lower_pin_enable) begin
         lwave_d = 1'b0;
      end
   end

   // Upper counter and its output wave
   always_comb begin
      ucnt_d  = ucnt_q;
      uwave_d = uwave_q;
      if (!urun) begin
         ucnt_d  = CNT_ZERO;
         uwave_d = 1'b0;
      end else if (cascade) begin
         // Cascaded: advances only on the lower carry
         if (match16) begin
            ucnt_d = CNT_ZERO;
         end else if (ucarry) begin
            ucnt_d = ucnt_q + 8'h01;
         end
      end else if (pwm) begin
         // Match wins over a same-cycle overflow
         if (utick) begin
            ucnt_d = ucnt_q + 8'h01;
         end
         if (umatch) begin
            uwave_d = 1'b0;
         end else if (uovf) begin
            uwave_d = 1'b1;
         end
      end else if (umatch) begin
         // Interval mode restarts and toggles on match
         ucnt_d  = CNT_ZERO;
         uwave_d = ~uwave_q;
      end else if (utick) begin
         ucnt_d = ucnt_q + 8'h01;
      end
      if (!ctrl_q.upper_pin_enable) begin
         uwave_d = 1'b0;
      end
   end

   wire uirq_d = ~cascade & umatch;
   wire lirq_d = match16 | lmatch;

   // Carrier gate and buffer
   wire car_wr = wr & hit_car;
   always_comb begin
      car_d = car_q;
      if (carrier && uirq_d) begin
         car_d.carrier_gate = car_q.carrier_gate_buffer;
      end
      if (car_wr) begin
         // A write sets the gate over a same-cycle reload only if upper irq stands or lower pin is off
         car_d.remote_out_select   = pwdata[RMC_BIT];
         car_d.carrier_gate_buffer = pwdata[GBUF_BIT];
         if (uirq_q) begin
            car_d.carrier_gate = pwdata[GBUF_BIT];
         end else if (!ctrl_q.lower_pin_enable) begin
            car_d.carrier_gate = pwdata[GATE_BIT];
         end
      end
   end

   logic lout_d;
   always_comb begin
      if (!ctrl_q.lower_pin_enable) begin
         lout_d = 1'b0;
      end else if (carrier) begin
         lout_d = car_q.carrier_gate &
                  (car_q.remote_out_select | lwave_q);
      end else begin
         lout_d = lwave_q;
      end
   end
   // Upper pin cannot be used while cascaded
   logic uout_d;
   always_comb begin
      if (!ctrl_q.upper_pin_enable || cascade) begin
         uout_d = 1'b0;
      end else begin
         uout_d = uwave_q;
      end
   end

   // Read data
   logic [DATA_W-1:0] rd;
   always_comb begin
      rd = RD_ZERO;
      if (hit_mode) begin
         rd[MODE_LSB +: MODE_W] = mode_q;
         rd[PWM_EN_BIT]         = pwm_en_q;
      end
      if (hit_ctrl) begin
         rd[UP_SEL_BIT:0] = ctrl_q;
      end
      if (hit_cmp) begin
         rd[HCMP_LSB+CNT_W-1:0] = cmp_q;
      end
      if (hit_car) begin
         rd[RMC_BIT:0] = car_q;
      end
      if (hit_st) begin
         rd[ST_UCNT_LSB +: CNT_W] = ucnt_q;
         rd[ST_LCNT_LSB +: CNT_W] = lcnt_q;
         rd[ST_UOUT_BIT]          = uout_q;
         rd[ST_LOUT_BIT]          = lout_q;
         rd[ST_GATE_BIT]          = car_q.carrier_gate;
         rd[ST_HSEL_BIT]          = hsel_q;
      end
   end

   // Bus handshake, answered one cycle after setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= RD_ZERO;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup & ~mapped;
         prdata_q  <= rd_go ? rd : RD_ZERO;
      end
   end

   // Software registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q   <= CTM_MODE_SPLIT;
         pwm_en_q <= 1'b0;
         ctrl_q   <= CTRL_RST;
         cmp_q    <= CMP_RST;
      end else begin
         if (wr && hit_mode) begin
            mode_q   <= ctm_mode_t'(pwdata[MODE_LSB +: MODE_W]);
            pwm_en_q <= pwdata[PWM_EN_BIT];
         end
         if (wr && hit_ctrl) begin
            ctrl_q <= pwdata[UP_SEL_BIT:0];
         end
         if (wr && hit_cmp) begin
            cmp_q <= pwdata[HCMP_LSB+CNT_W-1:0];
         end
      end
   end

   // Timer state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_s1_q   <= 1'b0;
         ev_s2_q   <= 1'b0;
         ev_s3_q   <= 1'b0;
         pre_q     <= 2'h0;
         ext_div_q <= 3'h0;
         lcnt_q    <= CNT_ZERO;
         ucnt_q    <= CNT_ZERO;
         hsel_q    <= 1'b0;
         lwave_q   <= 1'b0;
         uwave_q   <= 1'b0;
         car_q     <= CARRIER_RST;
      end else begin
         // Two synchroniser flops; the third only finds the rising edge
         ev_s1_q   <= event_input_pin;
         ev_s2_q   <= ev_s1_q;
         ev_s3_q   <= ev_s2_q;
         pre_q     <= pre_tick ? 2'h0 : pre_q + 2'h1;
         ext_div_q <= !lrun ? 3'h0 : ext_div_q + {2'h0, ev_rise};
         lcnt_q    <= lcnt_d;
         ucnt_q    <= ucnt_d;
         hsel_q    <= hsel_d;
         lwave_q   <= lwave_d;
         uwave_q   <= uwave_d;
         car_q     <= car_d;
      end
   end

   // Registered pins and interrupt pulses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         uirq_q <= 1'b0;
         lirq_q <= 1'b0;
         uout_q <= 1'b0;
         lout_q <= 1'b0;
      end else begin
         uirq_q <= uirq_d;
         lirq_q <= lirq_d;
         uout_q <= uout_d;
         lout_q <= lout_d;
      end
   end

   assign prdata        = prdata_q;
   assign pready        = pready_q;
   assign pslverr       = pslverr_q;
   assign upper_irq     = uirq_q;
   assign lower_irq     = lirq_q;
   assign upper_out_pin = uout_q;
   assign lower_out_pin = lout_q;

endmodule

// File: hdl/ctm_pkg.sv
// Constants, register map and carrier types of the cascaded timer pair
package ctm_pkg;

   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int CNT_W  = 8;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFF_MODE    = 12'h000;
   localparam logic [ADDR_W-1:0] OFF_CTRL    = 12'h004;
   localparam logic [ADDR_W-1:0] OFF_CMP     = 12'h008;
   localparam logic [ADDR_W-1:0] OFF_CARRIER = 12'h00c;
   localparam logic [ADDR_W-1:0] OFF_STATUS  = 12'h010;

   // Mode register fields
   localparam int MODE_LSB   = 0;
   localparam int MODE_W     = 2;
   localparam int PWM_EN_BIT = 2;

   // Control register fields
   localparam int UP_RUN_BIT  = 0;
   localparam int LO_RUN_BIT  = 1;
   localparam int UP_PIN_BIT  = 2;
   localparam int LO_PIN_BIT  = 3;
   localparam int LO_SEL_LSB  = 4;
   localparam int UP_SEL_BIT  = 7;

   // Compare register fields
   localparam int UCMP_LSB = 0;
   localparam int LCMP_LSB = 8;
   localparam int HCMP_LSB = 16;

   // Carrier control register fields
   localparam int GATE_BIT   = 0;
   localparam int GBUF_BIT   = 1;
   localparam int RMC_BIT    = 2;

   // Status register fields
   localparam int ST_UCNT_LSB = 0;
   localparam int ST_LCNT_LSB = 8;
   localparam int ST_UOUT_BIT = 16;
   localparam int ST_LOUT_BIT = 17;
   localparam int ST_GATE_BIT = 18;
   localparam int ST_HSEL_BIT = 19;

   // Lower timer count clock selections
   localparam logic [2:0] SEL_MAIN     = 3'h0;
   localparam logic [2:0] SEL_MAIN_D4  = 3'h1;
   localparam logic [2:0] SEL_EXT_D1   = 3'h2;
   localparam logic [2:0] SEL_EXT_D2   = 3'h3;
   localparam logic [2:0] SEL_EXT_D4   = 3'h4;
   localparam logic [2:0] SEL_EXT_D8   = 3'h5;

   localparam logic [1:0] PRE_LAST  = 2'h3;
   localparam logic [7:0] CNT_ZERO  = 8'h00;
   localparam logic [7:0] CNT_TOP   = 8'hff;
   localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

   typedef enum logic [1:0] {
      CTM_MODE_SPLIT,
      CTM_MODE_CASCADE,
      CTM_MODE_CARRIER
   } ctm_mode_t;

   typedef struct packed {
      logic       upper_sel;
      logic [2:0] lower_sel;
      logic       lower_pin_enable;
      logic       upper_pin_enable;
      logic       lower_run;
      logic       upper_run;
   } ctm_ctrl_t;

   typedef struct packed {
      logic [CNT_W-1:0] carrier_high_compare;
      logic [CNT_W-1:0] lower_compare;
      logic [CNT_W-1:0] upper_compare;
   } ctm_cmp_t;

   typedef struct packed {
      logic remote_out_select;
      logic carrier_gate_buffer;
      logic carrier_gate;
   } ctm_carrier_t;

   localparam ctm_ctrl_t    CTRL_RST    = '0;
   localparam ctm_cmp_t     CMP_RST     = '0;
   localparam ctm_carrier_t CARRIER_RST = '0;

endpackage

// File: dv/ctm_sva.sv
// Port-level assertions for the cascaded timer pair
`timescale 1ns/1ns
module ctm_sva #(
   parameter int PRE_DIV = 4
) (
   input wire logic                        pclk,
   input wire logic                        presetn,
   input wire logic                        psel,
   input wire logic                        penable,
   input wire logic                        pwrite,
   input wire logic [ctm_pkg::ADDR_W-1:0] paddr,
   input wire logic [ctm_pkg::DATA_W-1:0] pwdata,
   input wire logic [ctm_pkg::DATA_W-1:0] prdata,
   input wire logic                        pready,
   input wire logic                        pslverr,
   input wire logic                        event_input_pin,
   input wire logic                        upper_out_pin,
   input wire logic                        lower_out_pin,
   input wire logic                        upper_irq,
   input wire logic                        lower_irq
);
   import ctm_pkg::*;
   logic [2:0] mode_q;
   ctm_ctrl_t  ctrl_q;
   wire        wr_en  = psel && penable && pready && pwrite;
   wire        casc   = mode_q[1:0] == CTM_MODE_CASCADE;
   wire        carr   = mode_q[1:0] == CTM_MODE_CARRIER;
   wire        pwm    = mode_q[PWM_EN_BIT] && mode_q[1:0] == CTM_MODE_SPLIT;
   wire        mapped = paddr inside {OFF_MODE, OFF_CTRL, OFF_CMP, OFF_CARRIER, OFF_STATUS};

   // Shadow of the mode and control registers, taken from completed writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= 3'h0;
         ctrl_q <= CTRL_RST;
      end else if (wr_en && paddr == OFF_MODE) begin
         mode_q <= pwdata[2:0];
      end else if (wr_en && paddr == OFF_CTRL) begin
         ctrl_q <= pwdata[7:0];
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_ready_next: assert property (psel && !penable |=> pready)
      else $error("no pready after setup");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("pready outside access");
   a_err_map: assert property (pready |-> pslverr == !mapped)
      else $error("pslverr wrong for address");
   a_rdata_zero: assert property (!pready || pwrite || pslverr |-> prdata == RD_ZERO)
      else $error("prdata not zero");
   a_no_upper_irq: assert property (casc [*3] |-> !upper_irq)
      else $error("upper irq in cascade mode");
   a_pin_idle: assert property ((!ctrl_q.lower_pin_enable) [*3] |-> !lower_out_pin)
      else $error("lower pin high while disabled");
   a_run_off: assert property ((!ctrl_q.lower_run) [*3] |-> !lower_out_pin)
      else $error("lower pin high while stopped");
   a_match_toggle: assert property (
      !carr && ctrl_q.lower_pin_enable && ctrl_q.lower_run && lower_irq
      |=> lower_out_pin != $past(lower_out_pin))
      else $error("lower pin did not toggle on match");
   a_pwm_low: assert property (
      pwm && ctrl_q.upper_pin_enable && ctrl_q.upper_run && upper_irq |=> !upper_out_pin)
      else $error("pwm output not low after match");
endmodule

bind ctm_timer_top ctm_sva #(.PRE_DIV(PRE_DIV)) i_sva (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .event_input_pin(event_input_pin), .upper_out_pin(upper_out_pin),
   .lower_out_pin(lower_out_pin), .upper_irq(upper_irq), .lower_irq(lower_irq));

// File: dv/ctm_event_src.sv
// Behavioural external event source driving the timer's event pin
`timescale 1ns/1ns
module ctm_event_src (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        start,
   input  wire logic [15:0] num,
   output logic             busy,
   output logic             event_input_pin
);
   logic [15:0] left_q;
   logic [2:0]  ph_q;
   assign busy = left_q != 16'h0000;
   // Pulses last four clocks so the input synchroniser never drops one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         left_q          <= 16'h0000;
         ph_q            <= 3'h0;
         event_input_pin <= 1'b0;
      end else if (start) begin
         left_q <= num;
         ph_q   <= 3'h0;
      end else begin
         ph_q            <= ph_q + 3'h1;
         event_input_pin <= busy && ph_q[2];
         if (busy && ph_q == 3'h7) left_q <= left_q - 16'h0001;
      end
   end
endmodule

// File: dv/ctm_timer_top_tb.sv
// Self-checking bench for the cascaded timer pair
`timescale 1ns/1ns
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
$display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module ctm_timer_top_tb;
   import ctm_pkg::*;
   logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic              event_input_pin, upper_out_pin, lower_out_pin, upper_irq, lower_irq;
   logic              ev_go, ev_busy;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, rd;
   logic [15:0]       ev_num;
   int                num_errors, num_checks, cyc, lo_n, up_n, w;

   ctm_timer_top #(.PRE_DIV(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .event_input_pin(event_input_pin),
      .upper_out_pin(upper_out_pin), .lower_out_pin(lower_out_pin),
      .upper_irq(upper_irq), .lower_irq(lower_irq));
   ctm_event_src i_src (.pclk(pclk), .presetn(presetn), .start(ev_go), .num(ev_num),
      .busy(ev_busy), .event_input_pin(event_input_pin));

   always #25 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      lo_n += int'(lower_irq === 1'b1);
      up_n += int'(upper_irq === 1'b1);
      if (cyc == 20000) begin
         num_errors++;
         stop_test();
      end
   end

   task automatic xfer(input logic wrt, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wrt;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      for (n = 0; n < 50 && pready !== 1'b1; n++) @(posedge pclk);
      num_errors += int'(n == 50);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic events(input logic [15:0] cnt);
      int n;
      @(posedge pclk);
      ev_num <= cnt;
      ev_go  <= 1'b1;
      @(posedge pclk);
      ev_go <= 1'b0;
      repeat (2) @(posedge pclk);
      for (n = 0; n < 9000 && ev_busy === 1'b1; n++) @(posedge pclk);
      repeat (6) @(posedge pclk);
   endtask

   function automatic logic pin(input logic up);
      return up ? upper_out_pin : lower_out_pin;
   endfunction

   // Width in clocks of the next full stretch of the pin at level lvl
   task automatic span(input logic up, input logic lvl);
      for (int n = 0; n < 600 && pin(up) === lvl; n++) @(posedge pclk);
      for (int n = 0; n < 600 && pin(up) !== lvl; n++) @(posedge pclk);
      for (w = 0; w < 600 && pin(up) === lvl; w++) @(posedge pclk);
   endtask

   task automatic stop_test();
      if (num_errors == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      pclk    = 1'b0;
      presetn = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = '0;
      pwdata  = '0;
      ev_go   = 1'b0;
      ev_num  = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      xfer(1'b1, OFF_STATUS, 32'hffff_ffff);
      xfer(1'b0, OFF_STATUS, 32'h0000_0000);
      `CHK("status", 32'h0000_0000, rd)
      xfer(1'b0, 12'h014, 32'h0000_0000);
      `CHK("unmapped", 1'b1, er)
      xfer(1'b1, OFF_CARRIER, 32'h0000_0005);
      xfer(1'b0, OFF_CARRIER, 32'h0000_0000);
      `CHK("carrier_reg", 32'h0000_0005, rd)
      // Cascaded event counting with upper run left off
      xfer(1'b1, OFF_MODE, 32'h0000_0001);
      xfer(1'b1, OFF_CMP, 32'h0000_0201);
      xfer(1'b1, OFF_CTRL, 32'h0000_0022);
      events(16'd258);
      xfer(1'b0, OFF_STATUS, 32'h0000_0000);
      `CHK("count16", 16'h0201, rd[15:0])
      `CHK("early_irq", 0, lo_n)
      events(16'd1);
      xfer(1'b0, OFF_STATUS, 32'h0000_0000);
      `CHK("wrap", 16'h0000, rd[15:0])
      `CHK("lower_irqs", 1, lo_n)
      `CHK("upper_irqs", 0, up_n)
      events(16'd3);
      xfer(1'b1, OFF_CTRL, 32'h0000_0021);
      events(16'd2);
      xfer(1'b0, OFF_STATUS, 32'h0000_0000);
      `CHK("stopped", 16'h0000, rd[15:0])
      for (int s = 2; s < 6; s++) begin
         xfer(1'b1, OFF_CTRL, 32'(s << 4));
         xfer(1'b1, OFF_CTRL, 32'((s << 4) | 2));
         events(16'd8);
         xfer(1'b0, OFF_STATUS, 32'h0000_0000);
         `CHK("ext_div", 8 >> (s - 2), rd[15:8])
      end
      // 16-bit square wave, period of eight clocks
      xfer(1'b1, OFF_CTRL, 32'h0000_0050);
      xfer(1'b1, OFF_CTRL, 32'h0000_0008);
      `CHK("pin_init", 1'b0, lower_out_pin)
      xfer(1'b1, OFF_CMP, 32'h0000_0300);
      xfer(1'b1, OFF_CTRL, 32'h0000_000a);
      span(1'b0, 1'b1);
      `CHK("square_high", 4, w)
      span(1'b0, 1'b0);
      xfer(1'b1, OFF_CTRL, 32'h0000_0008);
      repeat (3) @(posedge pclk);
      `CHK("square_stop", 1'b0, lower_out_pin)
      // Pulse generator on main clock and on main clock divided by four
      xfer(1'b1, OFF_MODE, 32'h0000_0000);
      xfer(1'b1, OFF_CMP, 32'h0004_0200);
      for (int s = 0; s < 2; s++) begin
         xfer(1'b1, OFF_CTRL, 32'h0000_0008);
         xfer(1'b1, OFF_CTRL, 32'((s << 4) | 8));
         xfer(1'b1, OFF_CTRL, 32'((s << 4) | 10));
         span(1'b0, 1'b0);
         `CHK("ppg_low", 3 << (2 * s), w)
         span(1'b0, 1'b1);
         `CHK("ppg_high", 5 << (2 * s), w)
      end
      // Free-running PWM on the upper timer
      xfer(1'b1, OFF_CTRL, 32'h0000_0000);
      xfer(1'b1, OFF_MODE, 32'h0000_0004);
      xfer(1'b1, OFF_CMP, 32'h0000_0040);
      xfer(1'b1, OFF_CTRL, 32'h0000_0005);
      span(1'b1, 1'b1);
      `CHK("pwm_high", 65, w)
      span(1'b1, 1'b0);
      `CHK("pwm_low", 191, w)
      // Gated carrier
      xfer(1'b1, OFF_CTRL, 32'h0000_0000);
      xfer(1'b1, OFF_MODE, 32'h0000_0002);
      xfer(1'b1, OFF_CMP, 32'h0002_0107);
      xfer(1'b1, OFF_CARRIER, 32'h0000_0002);
      xfer(1'b1, OFF_CTRL, 32'h0000_000b);
      // Skip the stretch cut short when the first reload opens the gate
      repeat (12) @(posedge pclk);
      span(1'b0, 1'b1);
      `CHK("carrier_high", 3, w)
      span(1'b0, 1'b0);
      `CHK("carrier_low", 2, w)
      for (int n = 0; n < 20 && upper_irq !== 1'b1; n++) @(posedge pclk);
      xfer(1'b1, OFF_CARRIER, 32'h0000_0002);
      xfer(1'b0, OFF_CARRIER, 32'h0000_0000);
      `CHK("gate_locked", 32'h0000_0003, rd)
      // Land the next write in the cycle the upper interrupt stands
      for (int n = 0; n < 20 && upper_irq !== 1'b1; n++) @(posedge pclk);
      repeat (5) @(posedge pclk);
      xfer(1'b1, OFF_CARRIER, 32'h0000_0000);
      xfer(1'b0, OFF_CARRIER, 32'h0000_0000);
      `CHK("gate_reload", 32'h0000_0000, rd)
      repeat (12) @(posedge pclk);
      for (int k = 0; k < 10; k++) begin
         @(posedge pclk);
         `CHK("gate_off", 1'b0, lower_out_pin)
      end
      stop_test();
   end
endmodule
